//--- rtl/scs_pkg.sv
package scs_pkg;
    // Control register bit positions
    localparam int GYRO_EN_BIT = 0;
    localparam int THREE_WIRE_BIT = 5;
    localparam int ACCEL_CHAIN_EN_BIT = 4;
    localparam logic [7:0] GYRO_STAB_CONTROL_RESET = 8'h00;
    localparam logic [7:0] ACCEL_STAB_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE3_CONTROL = 8'h21;
    localparam logic [7:0] MODE4_CONTROL = 8'h31;
    // Output data addresses
    localparam logic [7:0] GYRO_OUT_FIRST = 8'h22;
    localparam logic [7:0] GYRO_OUT_LAST = 8'h27;
    localparam logic [7:0] ACCEL_OUT_FIRST = 8'h28;
    localparam logic [7:0] ACCEL_OUT_LAST = 8'h2D;
    // Timing
    localparam int CLOCK_MHZ = 100;
    localparam int TURN_ON_MS = 70;
    localparam int BOOT_MS = 10;
    localparam int HOST_WAIT_MS = 74;
    localparam int TURN_ON_CYCLES = TURN_ON_MS * 1000 * CLOCK_MHZ;
    localparam int BOOT_CYCLES = BOOT_MS * 1000 * CLOCK_MHZ;
    // One sample period at 6.66 kHz, rounded up
    localparam int SAMPLE_RATE_HZ = 6660;
    localparam int SAMPLE_CYCLES = (CLOCK_MHZ * 1000000 + SAMPLE_RATE_HZ - 1) / SAMPLE_RATE_HZ;
    localparam int GYRO_LP_SETTLE_00 = 27;
    localparam int ACCEL_LP_SETTLE_000 = 11;
    localparam int CNT_W = 32;
    localparam int SMP_W = 11;

    typedef struct packed {
        logic [7:0] gyro_stab_control;
        logic [7:0] accel_stab_control;
        logic [1:0] gyro_lowpass_stage;
        logic hp_enable;
        logic [1:0] hp_mode;
    } scs_config_type;

    typedef struct packed {
        logic gyro_valid;
        logic accel_valid;
        logic gyro_settling;
        logic three_wire;
        logic booted;
    } scs_status_type;

    typedef enum logic [1:0] {
        GYRO_OFF,
        GYRO_TURN_ON,
        GYRO_SETTLE,
        GYRO_RUN
    } scs_gyro_state_type;

    // Low-pass stage settling in samples
    function automatic logic [SMP_W-1:0] gyro_lp_samples(input logic [1:0] sel);
        unique case (sel)
            2'b00: gyro_lp_samples = SMP_W'(GYRO_LP_SETTLE_00);
            2'b01: gyro_lp_samples = SMP_W'(36);
            2'b10: gyro_lp_samples = SMP_W'(50);
            2'b11: gyro_lp_samples = SMP_W'(18);
        endcase
    endfunction

    function automatic logic [SMP_W-1:0] accel_lp_samples(input logic [2:0] sel);
        unique case (sel)
            3'b000: accel_lp_samples = SMP_W'(ACCEL_LP_SETTLE_000);
            3'b001: accel_lp_samples = SMP_W'(21);
            3'b010: accel_lp_samples = SMP_W'(42);
            3'b011: accel_lp_samples = SMP_W'(80);
            3'b100: accel_lp_samples = SMP_W'(155);
            3'b101: accel_lp_samples = SMP_W'(305);
            3'b110: accel_lp_samples = SMP_W'(600);
            3'b111: accel_lp_samples = SMP_W'(1200);
        endcase
    endfunction
endpackage

//--- rtl/scs_chain_startup.sv
// Summary of operation
// - Gyro output invalid until filter settling elapses, after 70 ms turn-on unless gyro on via primary interface.
// - From all gyro off, mode 4 gyro valid after turn-on plus settling.
// - Gyro running in mode 3, adding accelerometer keeps first gyro sample correct.
// - Gyro on via primary interface skips turn-on; accelerometer always needs settling.
// - Gyro settling is max of high-pass (if enabled) and low-pass stage times.
// - Control value 21h starts gyro chain at 250 dps, 6.66 kHz, 3-wire.
// - Low-pass stage 00b settles in 27 samples at 6.66 kHz.
// - Gyro output data sits at addresses 22h to 27h.
// - Control value 31h starts gyro chain and sets accelerometer chain enable.
// - Accel control 00h runs accelerometer at 2 g, 6.66 kHz.
// - Accel low-pass 000b settles in 11 samples at 6.66 kHz.
// - Accel output data sits at addresses 28h to 2Dh.
// - Accelerometer path runs only while gyro path is enabled too.
// - Control bit 0 enables gyro chain; bit 5 selects 3-wire.
`timescale 1ns/1ps
`default_nettype none
module scs_chain_startup #(
    parameter int TURN_ON_CYC = scs_pkg::TURN_ON_CYCLES,
    parameter int BOOT_CYC = scs_pkg::BOOT_CYCLES,
    parameter int SAMPLE_CYC = scs_pkg::SAMPLE_CYCLES,
    parameter logic [31:0] HP_SETTLE_CYC_00 = 32'h0000_1000,
    parameter logic [31:0] HP_SETTLE_CYC_01 = 32'h0000_0800,
    parameter logic [31:0] HP_SETTLE_CYC_10 = 32'h0000_0400,
    parameter logic [31:0] HP_SETTLE_CYC_11 = 32'h0000_0200
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // Configuration
    input wire scs_pkg::scs_config_type CONFIG,
    input wire logic PRIMARY_GYRO_ON,
    // Output register read address
    input wire logic [7:0] READ_ADDR,
    // Status
    output scs_pkg::scs_status_type STATUS,
    output logic GYRO_ADDR_HIT,
    output logic ACCEL_ADDR_HIT,
    output logic READ_VALID
);
    import scs_pkg::*;

    scs_gyro_state_type gstate, next_gstate;
    logic [CNT_W-1:0] gcount, next_gcount;
    logic [CNT_W-1:0] acount, next_acount;
    logic [CNT_W-1:0] bcount, next_bcount;
    logic booted, next_booted;
    logic accel_valid, next_accel_valid;
    logic accel_was_on, next_accel_was_on;
    logic [CNT_W-1:0] gyro_target, next_gyro_target;
    logic [CNT_W-1:0] accel_target, next_accel_target;
    logic [CNT_W-1:0] gyro_settle_cyc, accel_settle_cyc, hp_cyc;
    logic gyro_en, accel_en, ghit, ahit;

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Sample count to clock cycles at the chain output rate
    function automatic logic [CNT_W-1:0] samples_to_cycles(input logic [SMP_W-1:0] n);
        samples_to_cycles = CNT_W'(n) * CNT_W'(SAMPLE_CYC);
    endfunction

    always_comb begin
        gyro_en = booted && CONFIG.gyro_stab_control[GYRO_EN_BIT];
        accel_en = gyro_en && CONFIG.gyro_stab_control[ACCEL_CHAIN_EN_BIT];
        unique case (CONFIG.hp_mode)
            2'b00: hp_cyc = HP_SETTLE_CYC_00;
            2'b01: hp_cyc = HP_SETTLE_CYC_01;
            2'b10: hp_cyc = HP_SETTLE_CYC_10;
            2'b11: hp_cyc = HP_SETTLE_CYC_11;
        endcase
        gyro_settle_cyc = samples_to_cycles(gyro_lp_samples(CONFIG.gyro_lowpass_stage));
        if (CONFIG.hp_enable && hp_cyc > gyro_settle_cyc) begin
            gyro_settle_cyc = hp_cyc;
        end
        accel_settle_cyc = samples_to_cycles(accel_lp_samples(CONFIG.accel_stab_control[5:3]));
    end

    // Boot wait, booted holds afterwards
    always_comb begin
        next_bcount = bcount;
        next_booted = booted;
        if (!booted) begin
            if (bcount >= CNT_W'(BOOT_CYC - 1)) begin
                next_booted = 1'b1;
            end else begin
                next_bcount = bcount + 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            bcount <= '0;
            booted <= 1'b0;
        end else begin
            bcount <= next_bcount;
            booted <= next_booted;
        end
    end

    // Settling targets freeze once a chain starts; a filter change cannot cut a wait short
    always_comb begin
        next_gyro_target = gyro_target;
        next_accel_target = accel_target;
        if (gstate == GYRO_OFF) begin
            next_gyro_target = gyro_settle_cyc;
        end
        if (!accel_en || !accel_was_on) begin
            next_accel_target = accel_settle_cyc;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            gyro_target <= '0;
            accel_target <= '0;
        end else begin
            gyro_target <= next_gyro_target;
            accel_target <= next_accel_target;
        end
    end

    // Gyro chain turn-on and settling
    always_comb begin
        next_gstate = gstate;
        next_gcount = gcount;
        if (!gyro_en) begin
            next_gstate = GYRO_OFF;
            next_gcount = '0;
        end else begin
            unique case (gstate)
                GYRO_OFF: begin
                    next_gcount = '0;
                    if (PRIMARY_GYRO_ON) begin
                        next_gstate = GYRO_SETTLE;
                    end else begin
                        next_gstate = GYRO_TURN_ON;
                    end
                end
                GYRO_TURN_ON: begin
                    if (gcount >= CNT_W'(TURN_ON_CYC - 1)) begin
                        next_gstate = GYRO_SETTLE;
                        next_gcount = '0;
                    end else begin
                        next_gcount = gcount + 1'b1;
                    end
                end
                GYRO_SETTLE: begin
                    if (gcount + 1'b1 >= gyro_target) begin
                        next_gstate = GYRO_RUN;
                        next_gcount = '0;
                    end else begin
                        next_gcount = gcount + 1'b1;
                    end
                end
                GYRO_RUN: begin
                    next_gstate = GYRO_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            gstate <= GYRO_OFF;
            gcount <= '0;
        end else begin
            gstate <= next_gstate;
            gcount <= next_gcount;
        end
    end

    // Accelerometer low-pass settling, restarts on every enable
    always_comb begin
        next_acount = acount;
        next_accel_valid = accel_valid;
        next_accel_was_on = accel_en;
        if (!accel_en || !accel_was_on) begin
            next_acount = '0;
            next_accel_valid = 1'b0;
        end else if (!accel_valid) begin
            if (acount + 1'b1 >= accel_target) begin
                next_accel_valid = 1'b1;
            end else begin
                next_acount = acount + 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            acount <= '0;
            accel_valid <= 1'b0;
            accel_was_on <= 1'b0;
        end else begin
            acount <= next_acount;
            accel_valid <= next_accel_valid;
            accel_was_on <= next_accel_was_on;
        end
    end

    always_comb begin
        ghit = in_range(READ_ADDR, GYRO_OUT_FIRST, GYRO_OUT_LAST);
        ahit = in_range(READ_ADDR, ACCEL_OUT_FIRST, ACCEL_OUT_LAST);
        GYRO_ADDR_HIT = ghit;
        ACCEL_ADDR_HIT = ahit;
        READ_VALID = (ghit && gstate == GYRO_RUN) || (ahit && accel_valid);
        STATUS.gyro_valid = (gstate == GYRO_RUN);
        STATUS.accel_valid = accel_valid;
        STATUS.gyro_settling = (gstate == GYRO_TURN_ON) || (gstate == GYRO_SETTLE);
        STATUS.three_wire = CONFIG.gyro_stab_control[THREE_WIRE_BIT];
        STATUS.booted = booted;
    end
endmodule // scs_chain_startup
`default_nettype wire

//--- tb/scs_chain_props.sv
`timescale 1ns/1ps
`default_nettype none
module scs_chain_props #(parameter int TURN_ON_CYC = 20, BOOT_CYC = 10, SAMPLE_CYC = 2,
    MAX_WAIT = 1100) (
    // Watched ports
    input wire logic CLOCK,
    input wire logic SRST,
    input wire scs_pkg::scs_config_type CONFIG,
    input wire logic PRIMARY_GYRO_ON,
    input wire logic [7:0] READ_ADDR,
    input wire scs_pkg::scs_status_type STATUS,
    input wire logic GYRO_ADDR_HIT,
    input wire logic ACCEL_ADDR_HIT,
    input wire logic READ_VALID
);
    import scs_pkg::*;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    wire logic g_on = CONFIG.gyro_stab_control[GYRO_EN_BIT];
    always_comb next_cnt = g_on && STATUS.booted ? cnt + 16'h0001 : 16'h0000;
    always_ff @(posedge CLOCK) cnt <= SRST ? 16'h0000 : next_cnt;
    logic [15:0] acnt;
    logic [15:0] next_acnt;
    wire logic a_on = g_on && CONFIG.gyro_stab_control[ACCEL_CHAIN_EN_BIT];
    always_comb next_acnt = a_on && STATUS.booted ? acnt + 16'h0001 : 16'h0000;
    always_ff @(posedge CLOCK) acnt <= SRST ? 16'h0000 : next_acnt;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    sequence s_boot; !STATUS.booted [*8] ##[1:4] STATUS.booted; endsequence
    property p_boot; $fell(SRST) |-> s_boot; endproperty
    a_boot: assert property (p_boot) else $error("boot delay");
    property p_hit; GYRO_ADDR_HIT == (READ_ADDR inside {[GYRO_OUT_FIRST:GYRO_OUT_LAST]}); endproperty
    a_hit: assert property (p_hit) else $error("gyro decode");
    property p_rv; READ_VALID == (GYRO_ADDR_HIT && STATUS.gyro_valid
        || ACCEL_ADDR_HIT && STATUS.accel_valid); endproperty
    a_rv: assert property (p_rv) else $error("read valid");
    property p_ton; STATUS.gyro_valid && !PRIMARY_GYRO_ON |-> cnt >= TURN_ON_CYC; endproperty
    a_ton: assert property (p_ton) else $error("turn-on short");
    property p_lp; STATUS.gyro_valid && CONFIG.gyro_lowpass_stage == 2'b00
        |-> cnt >= GYRO_LP_SETTLE_00 * SAMPLE_CYC; endproperty
    a_lp: assert property (p_lp) else $error("gyro settle short");
    property p_acc; STATUS.accel_valid |-> acnt > ACCEL_LP_SETTLE_000 * SAMPLE_CYC; endproperty
    a_acc: assert property (p_acc) else $error("accel early");
    property p_keep; STATUS.gyro_valid && g_on |=> STATUS.gyro_valid; endproperty
    a_keep: assert property (p_keep) else $error("gyro valid lost");
    property p_bound; g_on && STATUS.booted && cnt == MAX_WAIT |-> STATUS.gyro_valid;
    endproperty
    a_bound: assert property (p_bound) else $error("gyro never valid");
endmodule // scs_chain_props
bind scs_chain_startup scs_chain_props #(.TURN_ON_CYC(TURN_ON_CYC), .BOOT_CYC(BOOT_CYC),
    .SAMPLE_CYC(SAMPLE_CYC)) u_props (.CLOCK, .SRST, .CONFIG, .PRIMARY_GYRO_ON, .READ_ADDR,
    .STATUS, .GYRO_ADDR_HIT, .ACCEL_ADDR_HIT, .READ_VALID);
`default_nettype wire

//--- tb/scs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_host_model #(parameter int BOOT = 12, WAIT = 1100) (
    // Bench control
    input wire logic clock,
    input wire logic srst,
    input wire logic go,
    input wire logic mode4,
    input wire logic [4:0] filt,
    // Device configuration and host ready flag
    output scs_pkg::scs_config_type cfg,
    output logic ready
);
    import scs_pkg::*;
    int t;
    logic [7:0] want;
    always @(negedge clock) begin
        want = mode4 ? MODE4_CONTROL : MODE3_CONTROL;
        if (srst) begin
            t = -BOOT;
            cfg <= '0;
            ready <= 1'b0;
        end else if (t < 0) begin
            t++;
        end else if (!go) begin
            cfg.gyro_stab_control <= 8'h00;
            ready <= 1'b0;
        end else if (cfg.gyro_stab_control !== want) begin
            cfg <= '{want, 8'h00, filt[4:3], filt[2], filt[1:0]};
            t = 0;
            ready <= 1'b0;
        end else if (t < WAIT) begin
            t++;
        end else begin
            ready <= 1'b1;
        end
    end
endmodule // scs_host_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scs_pkg::*;
    localparam int HPC [4] = '{200, 150, 1024, 512};
    localparam int LPS [4] = '{27, 36, 50, 18};
    logic clock = 1'b0, srst = 1'b1, go = 1'b0, mode4 = 1'b0, prim = 1'b0;
    logic ready, ghit, ahit, rv;
    logic [7:0] addr = 8'h00;
    logic [4:0] filt = 5'h00;
    logic [31:0] lfsr = 32'hc442_709f;
    int n_fail = 0, total_checks = 0, gk = 0, ak = 0, bk = 0;
    scs_config_type cfg;
    scs_status_type st;
    initial forever #5 clock = ~clock;
    scs_host_model u_host (.clock, .srst, .go, .mode4, .filt, .cfg, .ready);
    scs_chain_startup #(.TURN_ON_CYC(20), .BOOT_CYC(10), .SAMPLE_CYC(2),
        .HP_SETTLE_CYC_00(32'h0000_00c8), .HP_SETTLE_CYC_01(32'h0000_0096)) dut (
        .CLOCK(clock), .SRST(srst), .CONFIG(cfg), .PRIMARY_GYRO_ON(prim), .READ_ADDR(addr),
        .STATUS(st), .GYRO_ADDR_HIT(ghit), .ACCEL_ADDR_HIT(ahit), .READ_VALID(rv));
    always @(posedge clock) begin
        bk <= srst ? 0 : bk + 1;
        gk <= cfg.gyro_stab_control[0] ? gk + 1 : 0;
        ak <= cfg.gyro_stab_control[0] && cfg.gyro_stab_control[4] ? ak + 1 : 0;
    end
    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cycle(input logic rnd, input logic [7:0] a);
        int ge;
        logic gh, ah;
        @(negedge clock);
        lfsr = step(lfsr);
        addr = rnd ? lfsr[7:0] : a;
        #1;
        gh = addr >= GYRO_OUT_FIRST && addr <= GYRO_OUT_LAST;
        ah = addr >= ACCEL_OUT_FIRST && addr <= ACCEL_OUT_LAST;
        ge = LPS[filt[4:3]] * 2;
        if (filt[2] && HPC[filt[1:0]] > ge) ge = HPC[filt[1:0]];
        ge += prim ? 0 : 20;
        chk(ghit, gh);
        chk(ahit, ah);
        chk(st.three_wire, cfg.gyro_stab_control[THREE_WIRE_BIT]);
        chk(st.booted, bk >= 10);
        if (gk + 4 < ge || gk > ge + 4) chk(st.gyro_valid, gk > ge);
        if (gk + 4 < ge || gk > ge + 4) chk(st.gyro_settling, gk > 0 && gk <= ge);
        if (ak < 18 || ak > 26) chk(st.accel_valid, ak > 22);
        if (ready) chk(rv, gh || (ah && mode4));
    endtask
    task automatic run();
        int i;
        i = 0;
        repeat (2) cycle(1'b1, 8'h00);
        while (!ready && i < 1200) begin
            cycle(1'b1, 8'h00);
            i++;
        end
        for (int a = 32; a < 48; a++) cycle(1'b0, 8'(a));
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8000) @(posedge clock);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        repeat (20) @(negedge clock);
        srst = 1'b0;
        for (int s = 0; s < 4; s++) begin
            go = 1'b0;
            repeat (3) cycle(1'b1, 8'h00);
            lfsr = step(lfsr);
            filt = lfsr[12:8];
            prim = s[1];
            mode4 = s != 0;
            go = 1'b1;
            run();
            if (s == 0) begin
                mode4 = 1'b1;
                run();
            end
        end
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
